/* rtl/fpu_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1: Each user data word keeps a 31-bit value in the store, programmable once.
// RL2: Bit 31 of each user data word is the never-programmed flag.
// RL3: Hardware lets each user data word be written at most once.
// RL4: An unwritten user data word reads all ones, flag included.
// RL5: Each read-enable protection bit governs reads of one 2-KB flash block.
// RL6: Each program-enable protection bit governs programming of one 2-KB block.
// RL7: All protection words load from the store during power-on reset.
// RL8: A fresh part reads every protection bit as one.
// RL9: Software writes to protection words can only clear bits.
// RL10: A cleared protection bit is temporary until committed.
// RL11: A committed cleared bit is permanent across resets.
// RL12: An uncommitted cleared bit returns to its stored value on power-on reset.
// RL13: An all-ones protection word enables the whole 256 KB array; the code has three words per kind, 96 blocks or 192 KB.
// RL14: After its first write a user data word drops its flag and ignores writes.
module fpu_regs
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [11:0]       regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [31:0]       regRdData,
  // Nonvolatile store port
  output logic      [2:0]        storeIndex,
  input  wire logic [31:0]       storeRdData,
  output logic                   storeWrite,
  output logic      [31:0]       storeWrData,
  // Protection outputs to the flash
  output logic      [95:0]       readEnableProtect,
  output logic      [95:0]       programEnableProtect,
  output logic                   regsReady
);
  // Word 0..1 user data, 2..4 read enable, 5..7 program enable
  logic [31:0] wordReg  [fpu_pkg::NUM_WORDS];
  logic [31:0] wordNext [fpu_pkg::NUM_WORDS];
  logic [31:0] rdDataReg;
  logic [31:0] rdDataNext;
  logic        loadValid;
  logic        commitWrite;
  logic        seqReady;
  logic        seqBusy;
  logic        commitReq;
  logic        wrAccept;
  logic [3:0]  wrSlot;
  logic        userHit;
  logic        protHit;

  // Map a byte offset to a word slot, 4'hF when unmapped
  function automatic logic [3:0] slotOf(input logic [11:0] a);
    case (a)
      fpu_pkg::OFF_USER_ZERO: slotOf = 4'h0;
      fpu_pkg::OFF_USER_ONE:  slotOf = 4'h1;
      fpu_pkg::OFF_RD_ONE:    slotOf = 4'h2;
      fpu_pkg::OFF_RD_TWO:    slotOf = 4'h3;
      fpu_pkg::OFF_RD_THREE:  slotOf = 4'h4;
      fpu_pkg::OFF_PG_ONE:    slotOf = 4'h5;
      fpu_pkg::OFF_PG_TWO:    slotOf = 4'h6;
      fpu_pkg::OFF_PG_THREE:  slotOf = 4'h7;
      default:                slotOf = 4'hF;
    endcase
  endfunction

  // A user write always drops the flag, whatever bit 31 carried
  function automatic logic [31:0] writeOnce(input logic [31:0] d);
    writeOnce = {1'b0, d[fpu_pkg::DATA_MSB:0]};
  endfunction

  // Clear-only merge: a written zero clears, a written one keeps the old bit
  function automatic logic [31:0] clearOnly(input logic [31:0] old, input logic [31:0] d);
    clearOnly = old & d;
  endfunction

  fpu_store_seq fpu_store_seq_i
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .commitReq   (commitReq),
    .loadValid   (loadValid),
    .commitWrite (commitWrite),
    .wordIndex   (storeIndex),
    .ready       (seqReady),
    .busy        (seqBusy)
  );

  // Sequencer checks: a whole load after reset, a whole ordered commit
  a_load_first: assert property (@(posedge core_clk) // RL7
    rst ##1 !rst
    |-> loadValid [*8] ##1 seqReady)
    else $error("load sequence wrong length");
  a_load_order: assert property (@(posedge core_clk) // RL7
    rst ##1 !rst
    |-> storeIndex == 3'h0 ##7 storeIndex == 3'h7)
    else $error("load did not walk every word");
  a_commit_len: assert property (@(posedge core_clk) disable iff (rst) // RL11
    commitReq
    |=> storeWrite [*8] ##1 !storeWrite)
    else $error("commit did not write eight words");
  a_commit_order: assert property (@(posedge core_clk) disable iff (rst) // RL11
    commitReq
    |=> storeIndex == 3'h0 ##7 storeIndex == 3'h7 && seqBusy)
    else $error("commit did not walk every word");

  // Commit request from the control register, taken only when idle
  assign commitReq = regWrite && seqReady && (regAddr == fpu_pkg::OFF_CTRL)
                     && regWrData[fpu_pkg::CTRL_COMMIT]; // RL10

  // Write decode; every write is refused while loading or committing
  always_comb
  begin
    wrSlot   = slotOf(regAddr);
    wrAccept = regWrite && seqReady && (wrSlot != 4'hF);
    userHit  = wrAccept && (wrSlot < 4'h2);
    protHit  = wrAccept && (wrSlot >= 4'h2);
  end

  // Word updates: load, user write-once, protection clear-only
  always_comb
  begin
    for (int i = 0; i < fpu_pkg::NUM_WORDS; i++)
      wordNext[i] = wordReg[i];
    if (loadValid)
      wordNext[storeIndex] = storeRdData; // RL7 RL12
    else if (userHit)
    begin
      // Write lands only while the flag is still set
      if (wordReg[wrSlot[0]][fpu_pkg::FLAG_BIT]) // RL3 RL14
        wordNext[wrSlot[0]] = writeOnce(regWrData); // RL1 RL2
    end
    else if (protHit)
      wordNext[wrSlot[2:0]] = clearOnly(wordReg[wrSlot[2:0]], regWrData); // RL9
  end

  // Word checks; words move only by a load or by an accepted write
  a_user_once: assert property (@(posedge core_clk) disable iff (rst) // RL3
    seqReady && !wordReg[0][fpu_pkg::FLAG_BIT]
    |=> $stable(wordReg[0]))
    else $error("user word zero changed after first write");
  a_user_one_once: assert property (@(posedge core_clk) disable iff (rst) // RL3
    seqReady && !wordReg[1][fpu_pkg::FLAG_BIT]
    |=> $stable(wordReg[1]))
    else $error("user word one changed after first write");
  a_user_flag_clear: assert property (@(posedge core_clk) disable iff (rst) // RL14
    regWrite && seqReady && regAddr == fpu_pkg::OFF_USER_ONE
    |=> !wordReg[1][fpu_pkg::FLAG_BIT])
    else $error("flag still set after write");
  a_user_zero_flag: assert property (@(posedge core_clk) disable iff (rst) // RL2 RL14
    regWrite && seqReady && regAddr == fpu_pkg::OFF_USER_ZERO
    |=> !wordReg[0][fpu_pkg::FLAG_BIT])
    else $error("flag of word zero still set after write");
  a_user_data: assert property (@(posedge core_clk) disable iff (rst) // RL1
    regWrite && seqReady && regAddr == fpu_pkg::OFF_USER_ZERO
    && wordReg[0][fpu_pkg::FLAG_BIT]
    |=> wordReg[0][fpu_pkg::DATA_MSB:0] == $past(regWrData[fpu_pkg::DATA_MSB:0]))
    else $error("user data not stored");
  a_prot_clear_only: assert property (@(posedge core_clk) disable iff (rst) // RL9
    seqReady && !$past(loadValid)
    |=> (wordReg[2] & ~$past(wordReg[2])) == fpu_pkg::ZERO_WORD)
    else $error("protection bit rose without load");
  a_busy_refuse: assert property (@(posedge core_clk) disable iff (rst) // RL10
    seqBusy && regWrite
    |=> $stable(wordReg[3]))
    else $error("write landed during commit");
  a_load_word: assert property (@(posedge core_clk) disable iff (rst) // RL12
    loadValid && storeIndex == 3'h3
    |=> wordReg[3] == $past(storeRdData))
    else $error("word not loaded from store");
  a_load_user: assert property (@(posedge core_clk) disable iff (rst) // RL4
    loadValid && storeIndex == 3'h0
    |=> wordReg[0] == $past(storeRdData))
    else $error("user word not loaded from store");
  a_load_pg_word: assert property (@(posedge core_clk) disable iff (rst) // RL7
    loadValid && storeIndex == 3'h6
    |=> wordReg[6] == $past(storeRdData))
    else $error("program word not loaded from store");

  // Read mux; data stands one cycle after the strobe
  always_comb
  begin
    logic [3:0] slot;
    slot = slotOf(regAddr);
    rdDataNext = fpu_pkg::ZERO_WORD;
    if (regRead)
    begin
      if (slot != 4'hF)
        rdDataNext = wordReg[slot[2:0]];
      else if (regAddr == fpu_pkg::OFF_STATUS)
      begin
        rdDataNext[fpu_pkg::STAT_READY] = seqReady;
        rdDataNext[fpu_pkg::STAT_BUSY]  = seqBusy;
      end
    end
  end

  // Read checks; the answer is the word as it stood at the strobe
  a_flag_msb: assert property (@(posedge core_clk) disable iff (rst) // RL2
    regRead && regAddr == fpu_pkg::OFF_USER_ZERO
    |=> regRdData[fpu_pkg::FLAG_BIT] == $past(wordReg[0][fpu_pkg::FLAG_BIT]))
    else $error("flag not on bit 31");
  a_read_prot: assert property (@(posedge core_clk) disable iff (rst) // RL5
    regRead && regAddr == fpu_pkg::OFF_RD_ONE
    |=> regRdData == $past(wordReg[2]))
    else $error("read protection word read back wrong");
  a_read_pg: assert property (@(posedge core_clk) disable iff (rst) // RL6
    regRead && regAddr == fpu_pkg::OFF_PG_THREE
    |=> regRdData == $past(wordReg[7]))
    else $error("program protection word read back wrong");

  // Registers start erased so a fresh part reads all ones before load
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < fpu_pkg::NUM_WORDS; i++)
        wordReg[i] <= fpu_pkg::ERASED_WORD; // RL4 RL8
      rdDataReg <= fpu_pkg::ZERO_WORD;
    end
    else
    begin
      for (int i = 0; i < fpu_pkg::NUM_WORDS; i++)
        wordReg[i] <= wordNext[i];
      rdDataReg <= rdDataNext;
    end
  end

  // Commit writes the live image back; a store cannot set bits again
  assign storeWrite  = commitWrite; // RL11
  assign storeWrData = wordReg[storeIndex];
  assign regRdData   = rdDataReg;
  assign regsReady   = seqReady;
  // Each bit enables one 2-KB block; all ones opens 96 blocks, 192 KB of the 256 KB array
  assign readEnableProtect    = {wordReg[4], wordReg[3], wordReg[2]}; // RL5 RL13
  assign programEnableProtect = {wordReg[7], wordReg[6], wordReg[5]}; // RL6 RL13

  // Output checks; a reset part opens every block until the load lands
  a_reset_erased: assert property (@(posedge core_clk) // RL4
    rst
    |=> wordReg[5] == fpu_pkg::ERASED_WORD && wordReg[1] == fpu_pkg::ERASED_WORD)
    else $error("reset value not all ones");
  a_reset_open: assert property (@(posedge core_clk) // RL8 RL13
    rst
    |=> readEnableProtect == {3{fpu_pkg::ERASED_WORD}}
    && programEnableProtect == {3{fpu_pkg::ERASED_WORD}})
    else $error("protection outputs not open after reset");
  a_prot_out: assert property (@(posedge core_clk) disable iff (rst) // RL5 RL9
    seqReady
    |=> (readEnableProtect & ~$past(readEnableProtect)) == 96'h0)
    else $error("read protection output bit rose");
  a_pg_prot_fall: assert property (@(posedge core_clk) disable iff (rst) // RL6 RL9
    seqReady
    |=> (programEnableProtect & ~$past(programEnableProtect)) == 96'h0)
    else $error("program protection output bit rose");
  a_commit_frozen: assert property (@(posedge core_clk) disable iff (rst) // RL10
    seqBusy
    |=> $stable(readEnableProtect) && $stable(programEnableProtect))
    else $error("protection changed during commit");
  c_user_write: cover property (@(posedge core_clk) regWrite && regAddr == fpu_pkg::OFF_USER_ZERO);
  c_prot_clear: cover property (@(posedge core_clk) regWrite && regAddr == fpu_pkg::OFF_PG_TWO);
  c_commit: cover property (@(posedge core_clk) commitReq);
  c_status: cover property (@(posedge core_clk) regRead && regAddr == fpu_pkg::OFF_STATUS);
  c_write_refused: cover property (@(posedge core_clk) regWrite && seqBusy);
endmodule
`default_nettype wire

/* rtl/fpu_store_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// Walks the nonvolatile store one word per cycle, for load or commit
module fpu_store_seq
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Control
  input  wire logic              commitReq,
  output logic                   loadValid,
  output logic                   commitWrite,
  output logic [2:0]             wordIndex,
  output logic                   ready,
  output logic                   busy
);
  fpu_pkg::fpu_state_t stateReg;
  fpu_pkg::fpu_state_t stateNext;
  logic [2:0]          idxReg;
  logic [2:0]          idxNext;

  // Next state; commit only accepted when idle
  always_comb
  begin
    stateNext = stateReg;
    idxNext   = idxReg;
    case (stateReg)
      fpu_pkg::ST_LOAD:
      begin
        idxNext = idxReg + 3'h1;
        if (idxReg == 3'(fpu_pkg::LOAD_CYCLES - 1)) // RL7
          stateNext = fpu_pkg::ST_IDLE;
      end
      fpu_pkg::ST_IDLE:
      begin
        idxNext = 3'h0;
        if (commitReq)
          stateNext = fpu_pkg::ST_COMMIT;
      end
      fpu_pkg::ST_COMMIT:
      begin
        idxNext = idxReg + 3'h1;
        if (idxReg == 3'(fpu_pkg::NUM_WORDS - 1)) // RL11
          stateNext = fpu_pkg::ST_IDLE;
      end
      default:
        stateNext = fpu_pkg::ST_LOAD;
    endcase
  end

  // State registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      stateReg <= fpu_pkg::ST_LOAD;
      idxReg   <= 3'h0;
    end
    else
    begin
      stateReg <= stateNext;
      idxReg   <= idxNext;
    end
  end

  assign loadValid   = (stateReg == fpu_pkg::ST_LOAD);
  assign commitWrite = (stateReg == fpu_pkg::ST_COMMIT);
  assign wordIndex   = idxReg;
  assign ready       = (stateReg == fpu_pkg::ST_IDLE);
  assign busy        = (stateReg == fpu_pkg::ST_COMMIT);
endmodule
`default_nettype wire

/* shared/fpu_pkg.sv */
`default_nettype none
package fpu_pkg;
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_USER_ZERO  = 12'h1E0;
  localparam logic [11:0] OFF_USER_ONE   = 12'h1E4;
  localparam logic [11:0] OFF_RD_ONE     = 12'h204;
  localparam logic [11:0] OFF_RD_TWO     = 12'h208;
  localparam logic [11:0] OFF_RD_THREE   = 12'h20C;
  localparam logic [11:0] OFF_PG_ONE     = 12'h404;
  localparam logic [11:0] OFF_PG_TWO     = 12'h408;
  localparam logic [11:0] OFF_PG_THREE   = 12'h40C;
  localparam logic [11:0] OFF_CTRL       = 12'h500;
  localparam logic [11:0] OFF_STATUS     = 12'h504;
  // Field positions
  localparam int          FLAG_BIT       = 31;
  localparam int          DATA_MSB       = 30;
  localparam int          CTRL_COMMIT    = 0;
  localparam int          STAT_READY     = 0;
  localparam int          STAT_BUSY      = 1;
  // Reset and erased values
  localparam logic [31:0] ERASED_WORD    = 32'hFFFFFFFF;
  localparam logic [31:0] ZERO_WORD      = 32'h00000000;
  // Word count and load length of the store image
  localparam int          NUM_WORDS      = 8;
  localparam int          LOAD_CYCLES    = 8;
  // Loader and commit states
  typedef enum logic [1:0]
  {
    ST_LOAD   = 2'b00,
    ST_IDLE   = 2'b01,
    ST_COMMIT = 2'b10
  } fpu_state_t;
endpackage
`default_nettype wire

/* tb/fpu_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fpu_regs_tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h00000000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdData;
  logic [2:0]  storeIndex;
  logic [31:0] storeRdData;
  logic        storeWrite;
  logic [31:0] storeWrData;
  logic [95:0] readEnableProtect;
  logic [95:0] programEnableProtect;
  logic        regsReady;
  logic [31:0] store [8] = '{32'hFFFFFFFF, 32'h12345678, 32'hFFFFFFFF, 32'hA5A5FFFF,
                             32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0F0FFFFF, 32'hFFFFFFFF};
  logic [31:0] expWord [8];
  logic [31:0] rdVal;
  logic [11:0] offs [8] = '{fpu_pkg::OFF_USER_ZERO, fpu_pkg::OFF_USER_ONE,
                            fpu_pkg::OFF_RD_ONE, fpu_pkg::OFF_RD_TWO, fpu_pkg::OFF_RD_THREE,
                            fpu_pkg::OFF_PG_ONE, fpu_pkg::OFF_PG_TWO, fpu_pkg::OFF_PG_THREE};
  // Ordinary cases: word index beside the data written to it
  logic [2:0]  rowIdx [10] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [31:0] rowData [10] = '{32'h80000055, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'hFFFF0000,
                                32'hFFFFFFFF, 32'h0000FFFF, 32'hFFFFFFFF, 32'h00FF00FF,
                                32'hFFFFFFFF, 32'h7FFFFFFE};
  // Value each row should read back afterwards
  logic [31:0] rowExp [10] = '{32'h00000055, 32'h00000055, 32'h12345678, 32'hFFFF0000,
                               32'hFFFF0000, 32'h0000FFFF, 32'hFFFFFFFF, 32'h00FF00FF,
                               32'h0F0FFFFF, 32'h7FFFFFFE};
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;

  fpu_regs fpu_regs_i
  (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .storeIndex(storeIndex), .storeRdData(storeRdData), .storeWrite(storeWrite),
    .storeWrData(storeWrData), .readEnableProtect(readEnableProtect),
    .programEnableProtect(programEnableProtect), .regsReady(regsReady)
  );

  // Nonvolatile store: combinational read, commit overwrites the image
  assign storeRdData = store[storeIndex];
  always @(posedge core_clk)
    if (storeWrite)
      store[storeIndex] <= storeWrData;

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      complete_run();
    end
  end

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic write_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, so it is taken mid-cycle
  task automatic read_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (regsReady !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    check(regsReady, 1'b1);
  endtask

  // Reset expectation is the store image as it stands now
  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check(regsReady, 1'b0);
    for (int i = 0; i < 8; i++)
      expWord[i] = store[i];
    wait_ready();
  endtask

  task automatic read_all();
    for (int i = 0; i < 8; i++)
    begin
      read_reg(offs[i], rdVal);
      check(rdVal, expWord[i]);
    end
    check(readEnableProtect, {expWord[4], expWord[3], expWord[2]});
    check(programEnableProtect, {expWord[7], expWord[6], expWord[5]});
  endtask

  // Write one word and predict it: user words once only, protection AND-only
  task automatic apply_row(input logic [2:0] idx, input logic [31:0] d);
    write_reg(offs[idx], d);
    if (idx < 3'h2)
    begin
      if (expWord[idx][31])
        expWord[idx] = {1'b0, d[30:0]};
    end
    else
      expWord[idx] = expWord[idx] & d;
    read_reg(offs[idx], rdVal);
    check(rdVal, expWord[idx]);
  endtask

  task automatic complete_run();
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    do_reset();
    read_all();
    for (int r = 0; r < 10; r++)
    begin
      apply_row(rowIdx[r], rowData[r]);
      check(rdVal, rowExp[r]);
    end
    read_all();
    // Unmapped place reads zero and its write clears nothing
    write_reg(12'h100, 32'h00000000);
    read_reg(12'h100, rdVal);
    check(rdVal, fpu_pkg::ZERO_WORD);
    read_all();
    // Uncommitted clears and user writes vanish on reset
    do_reset();
    read_all();
    apply_row(3'h0, 32'h00000AAA);
    apply_row(3'h2, 32'hFFFFF0F0);
    apply_row(3'h7, 32'h3FFFFFFF);
    write_reg(fpu_pkg::OFF_CTRL, 32'h00000001);
    read_reg(fpu_pkg::OFF_STATUS, rdVal);
    check(rdVal, 32'h00000002);
    // A write while the commit runs is refused
    write_reg(fpu_pkg::OFF_RD_TWO, 32'h00000000);
    wait_ready();
    read_reg(fpu_pkg::OFF_STATUS, rdVal);
    check(rdVal, 32'h00000001);
    for (int i = 0; i < 8; i++)
      check(store[i], expWord[i]);
    // Committed content survives a further reset
    do_reset();
    read_all();
    apply_row(3'h2, 32'hFFFFFFFF);
    apply_row(3'h0, 32'h00000555);
    complete_run();
  end
endmodule
`default_nettype wire
